/* File: rtl/external_data_move_stretch_consts.vh */
// shared constants for the machine cycle sequencer and data move stretch logic
`ifndef EXTERNAL_DATA_MOVE_STRETCH_CONSTS_VH
`define EXTERNAL_DATA_MOVE_STRETCH_CONSTS_VH
`define STATES_PER_CYCLE   3'h4
`define STRETCH_W          3
`define STRETCH_RESET      3'h1
`define STRETCH_LSB        0
`define STRETCH_MSB        2
`define CLOCK_CONTROL_REGISTER_RESET        8'h01
`define EXTERNAL_DATA_MOVE_BASE_CYCLES   4'h2
`define STROBE_ZERO_CLKS   6'h02
`define STROBE_STEP_CLKS   6'h04
`define ST_FIRST           4'h1
`define ST_SECOND          4'h2
`define ST_THIRD           4'h4
`define ST_FOURTH          4'h8
`define MAX_CLASS          4'h5
`endif

/* File: rtl/state_ring.v */
// four-state machine cycle ring, one state per clock period
`timescale 1ns/1ns
`include "external_data_move_stretch_consts.vh"
module state_ring
(
   input  wire       clock,      // system clock
   input  wire       arst_n,     // async reset, low active
   output reg  [3:0] state_r,    // one-hot current state
   output wire       cycle_end   // high in fourth state
);
   // next state rotates ascending, wraps fourth to first
   reg [3:0] state_nxt;          // next one-hot state
   always @*
   begin
      case (state_r)
         `ST_FIRST:  state_nxt = `ST_SECOND;
         `ST_SECOND: state_nxt = `ST_THIRD;
         `ST_THIRD:  state_nxt = `ST_FOURTH;
         `ST_FOURTH: state_nxt = `ST_FIRST;
         default:    state_nxt = `ST_FIRST;    // recover from bad code
      endcase
   end

   // state register
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         state_r <= `ST_FIRST;
      else
         state_r <= state_nxt;
   end

   assign cycle_end = state_r[3];
endmodule

/* File: rtl/machine_cycle_external_data_move_stretch.v */
// instruction cycle accounting and stretched external data move timing
`timescale 1ns/1ns
`include "external_data_move_stretch_consts.vh"
module machine_cycle_external_data_move_stretch
(
   input  wire        clock,          // 100 MHz system clock
   input  wire        arst_n,         // async reset, low active
   input  wire        clock_control_register_we,       // clock control register write strobe
   input  wire [7:0]  clock_control_register_wdata,    // clock control write data
   output reg  [7:0]  clock_control_register, // clock control register value
   input  wire        instr_start,    // decoder has a new instruction this cycle
   input  wire [3:0]  instr_cycles,   // decoded machine cycles, one to five
   input  wire        instr_is_external_data_move,  // instruction is external data move
   input  wire        external_data_move_write,     // move direction, high for write
   input  wire [15:0] external_data_move_addr,      // external data address
   input  wire [7:0]  external_data_move_wdata,     // data to write
   input  wire [7:0]  ext_rdata,      // external data bus in, from a pin
   output wire [3:0]  mc_state,       // one-hot machine state
   output wire        fetch_pulse,    // one fetch slot per machine cycle, none in access cycles
   output reg         busy_r,         // instruction in progress
   output reg         done_r,         // instruction finished, one cycle pulse
   output reg  [15:0] ext_addr_r,     // external address out
   output reg  [7:0]  ext_wdata_r,    // external data out
   output reg         ext_data_oe_n_r,// data bus enable, low while driving
   output reg         rd_n_r,         // read strobe, low active
   output reg         wr_n_r,         // write strobe, low active
   output reg  [7:0]  rdata_r         // captured read data
);
   localparam IDLE   = 3'b001;       // waiting for instruction
   localparam RUN    = 3'b010;       // ordinary instruction cycles
   localparam ACCESS = 3'b100;       // external data access cycles

   // timing walk of one instruction, counted in clocks from the start edge
   //
   // the start edge is the rising edge that ends a first state while idle;
   // busy rises there and stays up until the last fourth state has ended
   //
   // ordinary instruction of n machine cycles:
   //    the decoder count is clamped to one..five and loaded into left_r
   //    each fourth state counts left_r down by one
   //    the fourth state that sees left_r at one ends the instruction
   //    done pulses for one clock, in the first state that follows
   //    the next start may be taken at the end of that same first state
   //
   // external data move with stretch s:
   //    left_r is loaded with s plus two at the start edge
   //    the first machine cycle is the plain opcode fetch
   //    its fourth state moves the control into the access phase
   //    the strobe falls at that same edge, at the start of a first state
   //    the strobe stands 2 clocks for s zero, and 4 clocks per step above
   //    the access phase itself lasts s plus one machine cycles
   //    so the strobe always ends inside the access phase
   //    address and write data are loaded at the start edge
   //    they stay put until the next data move starts
   //
   // read data path:
   //    the data pins pass two flip-flops before any logic reads them
   //    that puts the synchronised value two clocks behind the pins
   //    capture therefore waits two clocks after the strobe is released
   //    the value taken then is the one the pins showed under the strobe
   //    for s zero this capture falls on the last clock of the access phase
   //
   // hazards and limits:
   //    the stretch field is read live; software must not change it
   //    while a data move is in flight, or the counts disagree
   //    a start request outside an idle first state is dropped silently
   //    the decoder is expected to hold its request for a whole state

   wire       cycle_end;             // last state of machine cycle
   wire [2:0] stretch;               // stretch select field
   reg  [2:0] fsm_r;                 // control state
   reg  [3:0] left_r;                // machine cycles still to run
   reg  [5:0] strobe_cnt_r;          // strobe clocks remaining
   reg  [5:0] strobe_len;            // strobe width for stretch
   reg  [7:0] rsync1_r;              // read bus first sync stage
   reg  [7:0] rsync2_r;              // read bus second sync stage
   reg        external_data_move_wr_r;             // latched direction
   reg        move_r;                // running instruction is a data move
   reg  [1:0] rd_end_r;              // delay line from read strobe release

   // sequencer of four states per machine cycle
   state_ring u_ring
   (
      .clock     (clock),
      .arst_n    (arst_n),
      .state_r   (mc_state),
      .cycle_end (cycle_end)
   );

   // one fetch per machine cycle, in first state while idle or running
   assign fetch_pulse = mc_state[0] & (fsm_r != ACCESS);

   // field select from clock control
   assign stretch = clock_control_register[`STRETCH_MSB:`STRETCH_LSB];

   // clock control register, stretch defaults to one
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         clock_control_register <= `CLOCK_CONTROL_REGISTER_RESET;
      else if (clock_control_register_we)
         clock_control_register <= clock_control_register_wdata;
   end

   // strobe width: 2 clocks at zero, else four per step
   always @*
   begin
      if (stretch == 3'h0)
         strobe_len = `STROBE_ZERO_CLKS;
      else
         strobe_len = {3'h0, stretch} * `STROBE_STEP_CLKS;
   end

   // read data pin synchroniser
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rsync1_r <= 8'h00;
         rsync2_r <= 8'h00;
      end
      else
      begin
         rsync1_r <= ext_rdata;
         rsync2_r <= rsync1_r;
      end
   end

   // instruction cycle control; single rising-edge clocking stands in
   // for the dual-edge internal timing of the original core
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fsm_r           <= IDLE;
         left_r          <= 4'h0;
         busy_r          <= 1'b0;
         done_r          <= 1'b0;
         strobe_cnt_r    <= 6'h00;
         ext_addr_r      <= 16'h0000;
         ext_wdata_r     <= 8'h00;
         ext_data_oe_n_r <= 1'b1;
         rd_n_r          <= 1'b1;
         wr_n_r          <= 1'b1;
         rdata_r         <= 8'h00;
         external_data_move_wr_r       <= 1'b0;
         move_r          <= 1'b0;
         rd_end_r        <= 2'b00;
      end
      else
      begin
         done_r <= 1'b0;
         // shift the release marker; the synchroniser lags two clocks
         rd_end_r <= {rd_end_r[0], 1'b0};
         // capture pin data seen while the read strobe was low
         if (rd_end_r[1])
            rdata_r <= rsync2_r;
         case (fsm_r)
            IDLE:
            begin
               // accept at start of a machine cycle only
               if (instr_start && mc_state[0])
               begin
                  busy_r <= 1'b1;
                  if (instr_is_external_data_move)
                  begin
                     // opcode fetch cycle first, access next
                     left_r    <= {1'b0, stretch} + `EXTERNAL_DATA_MOVE_BASE_CYCLES;
                     external_data_move_wr_r <= external_data_move_write;
                     move_r    <= 1'b1;      // remembered, not read live
                     ext_addr_r  <= external_data_move_addr;
                     ext_wdata_r <= external_data_move_wdata;
                     fsm_r     <= RUN;
                  end
                  else
                  begin
                     // cycles from decoder, one to five, unstretched
                     if (instr_cycles == 4'h0)
                        left_r <= 4'h1;
                     else if (instr_cycles > `MAX_CLASS)
                        left_r <= `MAX_CLASS;
                     else
                        left_r <= instr_cycles;
                     external_data_move_wr_r <= 1'b0;
                     move_r    <= 1'b0;      // plain instruction
                     fsm_r     <= RUN;
                  end
               end
            end
            RUN:
            begin
               // count machine cycles down at each fourth state
               if (cycle_end)
               begin
                  if (left_r == 4'h1)
                  begin
                     fsm_r  <= IDLE;
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                     left_r <= 4'h0;
                  end
                  else if (move_r)
                  begin
                     // fetch over, begin access cycles with strobe
                     left_r       <= left_r - 4'h1;
                     fsm_r        <= ACCESS;
                     strobe_cnt_r <= strobe_len;
                     rd_n_r       <= external_data_move_wr_r;
                     wr_n_r       <= ~external_data_move_wr_r;
                     ext_data_oe_n_r <= ~external_data_move_wr_r;
                  end
                  else
                     left_r <= left_r - 4'h1;
               end
            end
            ACCESS:
            begin
               // strobe width countdown, address and data held
               if (strobe_cnt_r != 6'h00)
               begin
                  strobe_cnt_r <= strobe_cnt_r - 6'h01;
                  if (strobe_cnt_r == 6'h01)
                  begin
                     if (!rd_n_r)
                        rd_end_r <= {rd_end_r[0], 1'b1}; // capture two clocks on
                     rd_n_r <= 1'b1;
                     wr_n_r <= 1'b1;
                  end
               end
               // processor held until stretched cycles run out
               if (cycle_end)
               begin
                  if (left_r == 4'h1)
                  begin
                     fsm_r  <= IDLE;
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                     left_r <= 4'h0;
                     move_r <= 1'b0;
                     ext_data_oe_n_r <= 1'b1;
                     rd_n_r <= 1'b1;
                     wr_n_r <= 1'b1;
                  end
                  else
                     left_r <= left_r - 4'h1;
               end
            end
            default:
               fsm_r <= IDLE;                        // recover from bad code
         endcase
      end
   end
   // data effect of instructions is outside this timing block
endmodule

/* File: dv/machine_cycle_external_data_move_stretch_chk.sv */
// port checks for the machine cycle ring and stretched data move strobes
`timescale 1ns/1ns
module machine_cycle_external_data_move_stretch_chk
(
   input wire        clock,                  // system clock
   input wire        arst_n,                 // async reset, low active
   input wire [7:0]  clock_control_register, // stretch select in bits 2..0
   input wire [3:0]  mc_state,               // one-hot machine state
   input wire        fetch_pulse,            // fetch slot
   input wire        busy_r,                 // instruction running
   input wire        done_r,                 // end pulse
   input wire [15:0] ext_addr_r,             // external address
   input wire [7:0]  ext_wdata_r,            // external write data
   input wire        ext_data_oe_n_r,        // data enable, low drives
   input wire        rd_n_r,                 // read strobe
   input wire        wr_n_r                  // write strobe
);
   wire       lo;    // either strobe active
   wire [5:0] exp_w; // strobe clocks for the selected stretch
   reg  [5:0] cnt_r; // clocks the strobe has been active
   assign lo = !rd_n_r || !wr_n_r;
   assign exp_w = (clock_control_register[2:0] == 3'h0) ? 6'h02 :
                  {1'b0, clock_control_register[2:0], 2'b00};
   // count active strobe clocks, cleared when idle
   always @(posedge clock or negedge arst_n)
      if (!arst_n)
         cnt_r <= 6'h00;
      else
         cnt_r <= lo ? cnt_r + 6'h01 : 6'h00;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // second to fourth state in order
   sequence ring_tail;
      mc_state == 4'h2 ##1 mc_state == 4'h4 ##1 mc_state == 4'h8;
   endsequence
   AST_RING: assert property (mc_state == 4'h1 |=> ring_tail ##1 mc_state == 4'h1)
      else $error("state ring out of order");
   AST_ONEHOT: assert property ($onehot(mc_state))
      else $error("machine state not one-hot");
   AST_FETCH: assert property (fetch_pulse |-> mc_state == 4'h1)
      else $error("fetch outside first state");
   AST_DONE: assert property (done_r |-> mc_state == 4'h1 ##1 !done_r)
      else $error("done not a single first state pulse");
   AST_EXCL: assert property (!(!rd_n_r && !wr_n_r))
      else $error("both strobes active");
   AST_WIDTH: assert property ($fell(lo) |-> cnt_r == exp_w)
      else $error("strobe width wrong for stretch");
   AST_HOLD: assert property (lo |-> $stable(ext_addr_r) && $stable(ext_wdata_r))
      else $error("address or data moved under strobe");
   AST_DRIVE: assert property (lo |-> ext_data_oe_n_r == wr_n_r)
      else $error("data enable wrong during strobe");
   AST_ACCESS: assert property ($rose(lo) |-> mc_state == 4'h1 && busy_r && !fetch_pulse)
      else $error("strobe not at start of access cycle");
endmodule
bind machine_cycle_external_data_move_stretch machine_cycle_external_data_move_stretch_chk machine_cycle_external_data_move_stretch_chk_i
   (.clock, .arst_n, .clock_control_register, .mc_state, .fetch_pulse, .busy_r, .done_r,
    .ext_addr_r, .ext_wdata_r, .ext_data_oe_n_r, .rd_n_r, .wr_n_r);

/* File: dv/ext_mem.sv */
// external data memory model answering the stretched strobes
`timescale 1ns/1ns
module ext_mem
(
   input  wire        clock, // system clock
   input  wire [15:0] addr,  // address from device
   input  wire [7:0]  wdata, // write data from device
   input  wire        oe_n,  // device drives data, low
   input  wire        rd_n,  // read strobe, low
   input  wire        wr_n,  // write strobe, low
   output wire [7:0]  rdata  // data bus toward device
);
   reg [7:0] mem [0:255]; // storage on the address low byte
   reg [1:0] hold;        // clocks of read data hold left
   // data valid in strobe and briefly after, inverted otherwise
   assign rdata = (!rd_n || hold != 2'h0) ? mem[addr[7:0]] : ~mem[addr[7:0]];
   // store writes only while the device drives the bus
   always @(posedge clock)
   begin
      if (!wr_n && !oe_n)
         mem[addr[7:0]] <= wdata;
      hold <= !rd_n ? 2'h3 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
   end
endmodule

/* File: dv/machine_cycle_external_data_move_stretch_tb.sv */
// self-checking bench for cycle accounting and stretched data moves
`timescale 1ns/1ns
module machine_cycle_external_data_move_stretch_tb;
   logic        clock, arst_n, clock_control_register_we, instr_start, instr_is_external_data_move, external_data_move_write;
   logic [7:0]  clock_control_register_wdata, external_data_move_wdata, clock_control_register, ext_wdata_r, rdata_r;
   logic [3:0]  instr_cycles, mc_state, mcs;
   logic [15:0] external_data_move_addr, ext_addr_r;
   wire  [7:0]  ext_rdata;
   logic        fetch_pulse, busy_r, done_r, ext_data_oe_n_r, rd_n_r, wr_n_r;
   logic [12:0] exp_q[$], e;  // {is read, cycles, data}
   logic [2:0]  stretch;      // bench copy of stretch select
   logic [7:0]  a, d;
   int          n_errors, tests_run, cyc;
   machine_cycle_external_data_move_stretch machine_cycle_external_data_move_stretch_i (.clock, .arst_n, .clock_control_register_we,
      .clock_control_register_wdata, .clock_control_register, .instr_start, .instr_cycles, .instr_is_external_data_move,
      .external_data_move_write, .external_data_move_addr, .external_data_move_wdata, .ext_rdata, .mc_state, .fetch_pulse, .busy_r,
      .done_r, .ext_addr_r, .ext_wdata_r, .ext_data_oe_n_r, .rd_n_r, .wr_n_r, .rdata_r);
   ext_mem ext_mem_i (.clock, .addr(ext_addr_r), .wdata(ext_wdata_r), .oe_n(ext_data_oe_n_r),
      .rd_n(rd_n_r), .wr_n(wr_n_r), .rdata(ext_rdata));
   task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      tests_run++;
      if (ex !== got)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // start one instruction in the first state after an idle fourth state, start held one extra edge
   task run(input logic [3:0] n, input logic mv, input logic wr, input logic [7:0] ad,
            input logic [7:0] dt);
      @(negedge clock);
      while (!(mc_state === 4'h8 && (busy_r === 1'b0 || done_r === 1'b1)))
         @(negedge clock);
      @(posedge clock);
      instr_start <= 1'b1;
      instr_cycles <= n;
      instr_is_external_data_move <= mv;
      external_data_move_write <= wr;
      external_data_move_addr <= {8'h00, ad};
      external_data_move_wdata <= dt;
      exp_q.push_back({mv & !wr, mv ? {1'b0, stretch} + 4'h2 : n, dt});
      repeat (2) @(posedge clock);
      instr_start <= 1'b0;
   endtask
   // write stretch select once the pipe is empty, read it back
   task set_stretch(input logic [2:0] s);
      while (exp_q.size() != 0)
         @(negedge clock);
      @(posedge clock);
      clock_control_register_we <= 1'b1;
      clock_control_register_wdata <= {5'h00, s};
      @(posedge clock);
      clock_control_register_we <= 1'b0;
      stretch = s;
      @(negedge clock);
      chk("stretch", {5'h00, s}, {5'h00, clock_control_register[2:0]});
   endtask
   // count fourth states of the running instruction, compare at done
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         summarize;
      end
      if (mc_state === 4'h8 && (busy_r === 1'b1 || done_r === 1'b1))
         mcs = mcs + 4'h1;
      if (done_r === 1'b1)
      begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 13'h1fff;
         chk("cycles", {4'h0, e[11:8]}, {4'h0, mcs});
         if (e[12])
            chk("rdata", e[7:0], rdata_r);
         mcs = 4'h0;
      end
   end
   initial
   begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   initial
   begin
      {arst_n, clock_control_register_we, instr_start, instr_is_external_data_move, external_data_move_write} = 0;
      {clock_control_register_wdata, external_data_move_wdata, external_data_move_addr, instr_cycles, mcs} = 0;
      void'($urandom(58));
      stretch = 3'h1;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      @(negedge clock);
      chk("ccr reset", 8'h01, clock_control_register);
      run(4'h0, 1'b1, 1'b1, 8'h5a, 8'ha5);
      run(4'h0, 1'b1, 1'b0, 8'h5a, 8'ha5);
      for (int n = 1; n <= 5; n++)
         run(n[3:0], 1'b0, 1'b0, 8'h00, 8'h00);
      $display("test default move and cycle classes done");
      for (int s = 0; s < 8; s++)
      begin
         set_stretch(s[2:0]);
         a = $urandom;
         d = $urandom;
         run(4'h0, 1'b1, 1'b1, a, d);
         run(4'h0, 1'b1, 1'b0, a, d);
         run(4'h1, 1'b0, 1'b0, a, d);
      end
      set_stretch(3'h1);
      $display("test stretch sweep done");
      summarize;
   end
endmodule
